// File: bench/host_port_control_sva.sv
// Checker for the host port control register
`timescale 1ns/1ps
`default_nettype none
module host_port_control_sva
	import port_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Accesses
	input wire logic        host_wr,
	input wire logic [31:0] host_wdata,
	input wire logic [31:0] host_rdata,
	input wire logic        cpu_wr,
	input wire logic [31:0] cpu_wdata,
	input wire logic [31:0] cpu_rdata,
	// Outputs
	input wire logic        host_irq_n,
	input wire logic        cpu_irq,
	input wire logic        port_in_reset,
	input wire logic        read_ahead_pulse,
	input wire logic        first_half_lsb,
	input wire addr_route_t host_addr_route,
	input wire logic        cpu_addr_separate
);
	logic c_cpu_to_host_irq;
	logic h_ack;
	logic h_set;
	logic c_clr;
	assign c_cpu_to_host_irq = cpu_wr && cpu_wdata[2];
	assign h_ack = host_wr && host_wdata[2] && !c_cpu_to_host_irq;
	assign h_set = host_wr && host_wdata[1];
	assign c_clr = cpu_wr && cpu_wdata[1] && !h_set;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence raise_ack;
		c_cpu_to_host_irq ##1 h_ack;
	endsequence
	a_pin_inverse: assert property (host_irq_n == !host_rdata[2])
		else $error("host pin not inverse of flag");
	a_cpu_raise: assert property (c_cpu_to_host_irq |=> !host_irq_n)
		else $error("cpu write did not raise host irq");
	a_irq_cycle: assert property (raise_ack |=> host_irq_n)
		else $error("host ack did not clear irq");
	a_zero_hold: assert property (!c_cpu_to_host_irq && !h_ack |=> $stable(host_irq_n))
		else $error("host irq moved without write one");
	a_dsp_set: assert property (h_set |=> cpu_irq)
		else $error("host write did not set cpu irq");
	a_dsp_clear: assert property (c_clr |=> !cpu_irq)
		else $error("cpu write did not clear cpu irq");
	a_fetch_pulse: assert property (host_wr && host_wdata[4] |=>
		read_ahead_pulse && !host_rdata[4] && !cpu_rdata[4])
		else $error("prefetch pulse or readback wrong");
	a_order_mirror: assert property (host_rdata[8] == host_rdata[0]
		&& first_half_lsb == host_rdata[0])
		else $error("halfword status mismatch");
	a_route_sel: assert property (host_addr_route == (!host_rdata[9] ?
		ROUTE_COMBINED : host_rdata[11] ? ROUTE_READ_REG : ROUTE_WRITE_REG))
		else $error("address route wrong");
	a_soft_reset: assert property (cpu_wr && cpu_wdata[7] && !$past(rst)
		|=> port_in_reset && host_rdata[7])
		else $error("cpu soft reset not taken");
	a_cpu_view: assert property (cpu_rdata == host_rdata && cpu_addr_separate)
		else $error("cpu view differs");
endmodule // host_port_control_sva
bind host_port_control host_port_control_sva u_sva (.clk(clk), .rst(rst),
	.host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
	.host_irq_n(host_irq_n), .cpu_irq(cpu_irq), .port_in_reset(port_in_reset),
	.read_ahead_pulse(read_ahead_pulse), .first_half_lsb(first_half_lsb),
	.host_addr_route(host_addr_route), .cpu_addr_separate(cpu_addr_separate));
`default_nettype wire

// File: bench/host_proc_model.sv
// Host processor model writing the control register
`timescale 1ns/1ps
`default_nettype none
module host_proc_model
(
	// Clock
	input  wire logic        clk,
	// Host write port
	output logic             host_wr,
	output logic      [31:0] host_wdata
);
	initial
	begin
		host_wr = 1'b0;
	end
	task automatic write(input logic [31:0] d);
		@(negedge clk);
		host_wr = 1'b1;
		host_wdata = d & ~32'h0000_0460;
		@(negedge clk);
		host_wr = 1'b0;
		host_wdata = ~host_wdata;
	endtask
endmodule // host_proc_model
`default_nettype wire

// File: bench/tb_host_port_control.sv
// Self-checking bench for the host port control register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin \
		compares++; \
		if ((a) !== (b)) \
			$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); \
		if ((a) !== (b)) \
			fail_count++; \
	end
module tb_host_port_control
	import port_ctrl_pkg::*;
;
	logic        clk, rst, host_boot, host_wr, cpu_wr;
	logic [31:0] host_wdata, cpu_wdata, host_rdata, cpu_rdata;
	logic        host_irq_n, cpu_irq, port_in_reset, read_ahead_pulse;
	logic        first_half_lsb, cpu_addr_separate;
	addr_route_t host_addr_route;
	int          fail_count = 0;
	int          compares = 0;
	host_port_control u_dut (.clk(clk), .rst(rst), .host_boot(host_boot),
		.host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.host_irq_n(host_irq_n), .cpu_irq(cpu_irq),
		.port_in_reset(port_in_reset), .read_ahead_pulse(read_ahead_pulse),
		.first_half_lsb(first_half_lsb), .host_addr_route(host_addr_route),
		.cpu_addr_separate(cpu_addr_separate));
	host_proc_model u_host (.clk(clk), .host_wr(host_wr),
		.host_wdata(host_wdata));
	task automatic results;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cpu_write(input logic [31:0] d);
		@(negedge clk);
		cpu_wr = 1'b1;
		cpu_wdata = d;
		@(negedge clk);
		cpu_wr = 1'b0;
		cpu_wdata = ~d;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		fail_count++;
		results();
	end
	initial
	begin
		rst = 1'b1;
		host_boot = 1'b0;
		cpu_wr = 1'b0;
		repeat (10) @(negedge clk);
		`CHK(host_rdata, 32'h0000_0088)
		`CHK({host_irq_n, cpu_irq}, 2'h2)
		rst = 1'b0;
		@(negedge clk);
		`CHK(host_rdata, 32'h0000_0088)
		cpu_write(32'h0000_0b81);
		`CHK(cpu_rdata, 32'h0000_0088)
		cpu_write(32'h0000_0000);
		`CHK({port_in_reset, cpu_addr_separate}, 2'h1)
		u_host.write(32'h0000_0a01);
		`CHK(host_rdata, 32'h0000_0b09)
		`CHK(host_addr_route, ROUTE_READ_REG)
		`CHK(first_half_lsb, 1'b1)
		u_host.write(32'h0000_0200);
		`CHK(host_rdata, 32'h0000_0208)
		`CHK(host_addr_route, ROUTE_WRITE_REG)
		u_host.write(32'h0000_0010);
		`CHK(read_ahead_pulse, 1'b1)
		`CHK(host_rdata, 32'h0000_0008)
		`CHK(host_addr_route, ROUTE_COMBINED)
		@(negedge clk);
		`CHK(read_ahead_pulse, 1'b0)
		cpu_write(32'h0000_0004);
		`CHK({host_irq_n, host_rdata[2]}, 2'h1)
		u_host.write(32'h0000_0000);
		`CHK(host_irq_n, 1'b0)
		u_host.write(32'h0000_0004);
		`CHK(host_rdata, 32'h0000_0008)
		// Raise and acknowledge on consecutive edges
		fork
			cpu_write(32'h0000_0004);
			begin
				@(negedge clk);
				u_host.write(32'h0000_0004);
			end
		join
		`CHK(host_irq_n, 1'b1)
		u_host.write(32'h0000_0002);
		`CHK(cpu_irq, 1'b1)
		cpu_write(32'h0000_0002);
		`CHK(cpu_irq, 1'b0)
		cpu_write(32'h0000_0084);
		`CHK(port_in_reset, 1'b1)
		u_host.write(32'h0000_0082);
		host_boot = 1'b1;
		rst = 1'b1;
		#10;
		`CHK({host_irq_n, cpu_irq}, 2'h2)
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		`CHK(host_rdata, 32'h0000_0008)
		results();
	end
endmodule // tb_host_port_control
`default_nettype wire

// File: pkg/ctrl_wr_if.sv
// Decoded write strobes for one register access port
`timescale 1ns/1ps
`default_nettype none
interface ctrl_wr_if;
	logic        wr;
	logic [31:0] wdata;

	modport src  (output wr, output wdata);
	modport sink (input wr, input wdata);
endinterface : ctrl_wr_if
`default_nettype wire

// File: pkg/port_ctrl_pkg.sv
// Constants and types for the host port control register
package port_ctrl_pkg;

	// ------------------------------------------------------------
	// Register layout
	// ------------------------------------------------------------
	localparam int unsigned CTRL_WIDTH        = 32;
	localparam int unsigned BIT_HALFWORD      = 0;
	localparam int unsigned BIT_HOST_TO_CPU   = 1;
	localparam int unsigned BIT_CPU_TO_HOST   = 2;
	localparam int unsigned BIT_RSVD_ONE      = 3;
	localparam int unsigned BIT_READ_AHEAD    = 4;
	localparam int unsigned BIT_SOFT_RESET    = 7;
	localparam int unsigned BIT_HALFWORD_STAT = 8;
	localparam int unsigned BIT_DUAL_MODE     = 9;
	localparam int unsigned BIT_ADDR_SELECT   = 11;

	// Reserved bit 3 always reads one
	localparam logic [31:0] CTRL_FIXED_ONES   = 32'h0000_0008;

	// Host-writable plain fields (select, dual, soft reset, halfword order)
	localparam logic [31:0] HOST_PLAIN_MASK   = 32'h0000_0a81;

	// Values after reset
	localparam logic        RST_HALFWORD      = 1'b0;
	localparam logic        RST_DUAL_MODE     = 1'b0;
	localparam logic        RST_ADDR_SELECT   = 1'b0;
	localparam logic        RST_IRQ           = 1'b0;
	localparam logic        RST_SOFT_RESET    = 1'b1;

	// Address register routing for host accesses
	typedef enum logic [1:0] {
		ROUTE_COMBINED,
		ROUTE_WRITE_REG,
		ROUTE_READ_REG
	} addr_route_t;

endpackage : port_ctrl_pkg

// File: rtl/addr_router.sv
// Chooses which address register a host address access reaches
`timescale 1ns/1ps
`default_nettype none
module addr_router
	import port_ctrl_pkg::*;
(
	// Configuration
	input  wire logic  dual_mode,
	input  wire logic  addr_select,
	// Routing result
	output addr_route_t route
);
	always_comb
	begin
		if (!dual_mode)
			route = ROUTE_COMBINED;
		else if (addr_select)
			route = ROUTE_READ_REG;
		else
			route = ROUTE_WRITE_REG;
	end
endmodule : addr_router
`default_nettype wire

// File: rtl/host_port_control.sv
// Host port control and configuration register
// Functional notes
// - Host has full read/write; CPU reads, plus three write-one actions (bits 1, 2, 7); a CPU zero write to bit 7
//   clears soft reset unless the host writes in the same cycle or it falls on the first edge after reset release.
// - CPU writing one to cpu_to_host_irq raises host interrupt.
// - CPU writing one to port_soft_reset enters port software reset.
// - Dual mode: address_reg_select zero picks write reg, one read reg.
// - dual_addr_mode zero combines both address registers for host.
// - CPU always reaches both address registers separately.
// - halfword_order_status mirrors halfword_order on every write.
// - port_soft_reset resets to zero on host-port boot, else one.
// - Host write of one to read_ahead_request posts a prefetch.
// - read_ahead_request always reads back zero.
// - Host interrupt pin, active low, is inverse of cpu_to_host_irq.
// - Host writing one clears cpu_to_host_irq, pin goes high.
// - Writing zero to cpu_to_host_irq changes nothing.
// - Host writing one sets host_to_cpu_irq; zero writes do nothing.
// - CPU writing one clears host_to_cpu_irq.
// - halfword_order zero: first halfword MS; one: first halfword LS.
// - Hardware reset clears both interrupt bits at once.
`timescale 1ns/1ps
`default_nettype none
module host_port_control
	import port_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Boot strap, sampled at reset release
	input  wire logic        host_boot,
	// Host (owner) register access
	input  wire logic        host_wr,
	input  wire logic [31:0] host_wdata,
	output logic      [31:0] host_rdata,
	// CPU (non-owner) register access
	input  wire logic        cpu_wr,
	input  wire logic [31:0] cpu_wdata,
	output logic      [31:0] cpu_rdata,
	// Interrupts
	output logic             host_irq_n,
	output logic             cpu_irq,
	// Port control outputs
	output logic             port_in_reset,
	output logic             read_ahead_pulse,
	output logic             first_half_lsb,
	output addr_route_t      host_addr_route,
	output logic             cpu_addr_separate
);
	// ------------------------------------------------------------
	// Access ports
	// ------------------------------------------------------------
	ctrl_wr_if host_if ();
	ctrl_wr_if cpu_if ();

	assign host_if.wr    = host_wr;
	assign host_if.wdata = host_wdata;
	assign cpu_if.wr     = cpu_wr;
	assign cpu_if.wdata  = cpu_wdata;

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	logic addr_select_ff;
	logic dual_mode_ff;
	logic halfword_ff;
	logic halfword_stat_ff;
	logic soft_reset_ff;
	logic read_ahead_ff;
	logic boot_pending_ff;
	logic nxt_addr_select;
	logic nxt_dual_mode;
	logic nxt_halfword;
	logic nxt_halfword_stat;
	logic nxt_soft_reset;
	logic nxt_read_ahead;
	logic nxt_boot_pending;

	always_comb
	begin
		nxt_addr_select   = addr_select_ff;
		nxt_dual_mode     = dual_mode_ff;
		nxt_halfword      = halfword_ff;
		nxt_halfword_stat = halfword_stat_ff;
		nxt_soft_reset    = soft_reset_ff;
		nxt_read_ahead    = 1'b0;
		nxt_boot_pending  = 1'b0;
		// Strap caught on the first edge after release
		// boot strap value
		if (boot_pending_ff)
			nxt_soft_reset = !host_boot;
		if (host_if.wr)
		begin
			nxt_addr_select = host_if.wdata[BIT_ADDR_SELECT];
			nxt_dual_mode   = host_if.wdata[BIT_DUAL_MODE];
			nxt_halfword    = host_if.wdata[BIT_HALFWORD];
			nxt_halfword_stat = host_if.wdata[BIT_HALFWORD];
			nxt_soft_reset  = host_if.wdata[BIT_SOFT_RESET];
			nxt_read_ahead  = host_if.wdata[BIT_READ_AHEAD];
		end
		if (cpu_if.wr && cpu_if.wdata[BIT_SOFT_RESET])
			nxt_soft_reset = 1'b1;
		else if (cpu_if.wr && !host_if.wr && !boot_pending_ff)
			nxt_soft_reset = soft_reset_ff & cpu_if.wdata[BIT_SOFT_RESET];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			addr_select_ff   <= RST_ADDR_SELECT;
			dual_mode_ff     <= RST_DUAL_MODE;
			halfword_ff      <= RST_HALFWORD;
			halfword_stat_ff <= RST_HALFWORD;
			soft_reset_ff    <= RST_SOFT_RESET;
			read_ahead_ff    <= 1'b0;
			boot_pending_ff  <= 1'b1;
		end
		else
		begin
			addr_select_ff   <= nxt_addr_select;
			dual_mode_ff     <= nxt_dual_mode;
			halfword_ff      <= nxt_halfword;
			halfword_stat_ff <= nxt_halfword_stat;
			soft_reset_ff    <= nxt_soft_reset;
			read_ahead_ff    <= nxt_read_ahead;
			boot_pending_ff  <= nxt_boot_pending;
		end
	end

	// ------------------------------------------------------------
	// Interrupt flags
	// ------------------------------------------------------------
	logic cpu_to_host_irq;
	logic host_to_cpu_irq;

	irq_flag u_cpu_to_host (
		.clk     (clk),
		.rst     (rst),
		.set_one (cpu_if.wr && cpu_if.wdata[BIT_CPU_TO_HOST]),
		.clr_one (host_if.wr && host_if.wdata[BIT_CPU_TO_HOST]),
		.flag    (cpu_to_host_irq)
	);

	irq_flag u_host_to_cpu (
		.clk     (clk),
		.rst     (rst),
		.set_one (host_if.wr && host_if.wdata[BIT_HOST_TO_CPU]),
		.clr_one (cpu_if.wr && cpu_if.wdata[BIT_HOST_TO_CPU]),
		.flag    (host_to_cpu_irq)
	);

	// ------------------------------------------------------------
	// Address routing
	// ------------------------------------------------------------
	// host routing
	addr_router u_router (
		.dual_mode   (dual_mode_ff),
		.addr_select (addr_select_ff),
		.route       (host_addr_route)
	);

	assign cpu_addr_separate = 1'b1;

	// ------------------------------------------------------------
	// Read-back and outputs
	// ------------------------------------------------------------
	logic [31:0] ctrl_view;

	always_comb
	begin
		ctrl_view = CTRL_FIXED_ONES;
		ctrl_view[BIT_ADDR_SELECT]   = addr_select_ff;
		ctrl_view[BIT_DUAL_MODE]     = dual_mode_ff;
		ctrl_view[BIT_HALFWORD_STAT] = halfword_stat_ff;
		ctrl_view[BIT_SOFT_RESET]    = soft_reset_ff;
		ctrl_view[BIT_READ_AHEAD]    = 1'b0;
		ctrl_view[BIT_CPU_TO_HOST]   = cpu_to_host_irq;
		ctrl_view[BIT_HOST_TO_CPU]   = host_to_cpu_irq;
		ctrl_view[BIT_HALFWORD]      = halfword_ff;
	end

	assign host_rdata       = ctrl_view;
	assign cpu_rdata        = ctrl_view;
	assign host_irq_n       = !cpu_to_host_irq;
	assign cpu_irq          = host_to_cpu_irq;
	assign port_in_reset    = soft_reset_ff;
	assign read_ahead_pulse = read_ahead_ff;
	assign first_half_lsb   = halfword_ff;

endmodule : host_port_control
`default_nettype wire

// File: rtl/irq_flag.sv
// Interrupt flag: one side sets by writing one, the other clears
`timescale 1ns/1ps
`default_nettype none
module irq_flag
	import port_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Write-one events
	input  wire logic set_one,
	input  wire logic clr_one,
	// Flag
	output logic      flag
);
	logic flag_ff;
	logic nxt_flag;

	always_comb
	begin
		nxt_flag = flag_ff;
		if (clr_one)
			nxt_flag = 1'b0;
		// Set wins over a clear in the same cycle
		if (set_one)
			nxt_flag = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flag_ff <= RST_IRQ;
		else
			flag_ff <= nxt_flag;
	end

	assign flag = flag_ff;
endmodule : irq_flag
`default_nettype wire
